// file: src/lsm_pkg.sv
// Shared types and constants for the load/store-multiple sequencer.
// Assumes one core clock; every memory-side signal is sampled on that clock.
package lsm_pkg;

    // Bus widths and register file shape
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int REG_COUNT = 16;
    localparam logic [3:0] PC_INDEX = 4'hF;

    // Address stepping
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] WIDE_FETCH_STEP = 32'h0000_0004;
    localparam logic [31:0] COMPACT_FETCH_STEP = 32'h0000_0002;
    localparam logic [31:0] FETCH_AHEAD = 32'h0000_0003;
    localparam logic [15:0] DOUBLE_PAIR = 16'h0003;

    // Sequencing counts
    localparam int CMD_BUF_DEPTH = 2;
    localparam logic [1:0] REFILL_LAST = 2'h3;
    localparam logic TRANS_USER = 1'b0;

    // Cycle types as {request_n, sequential}
    localparam logic [1:0] CYC_NONSEQ = 2'h0;
    localparam logic [1:0] CYC_SEQ = 2'h1;
    localparam logic [1:0] CYC_IDLE = 2'h2;

    // Operations handed over by decode
    typedef enum logic [1:0] {OP_STORE, OP_BLOCK_LOAD, OP_BLOCK_STORE, OP_DOUBLE_LOAD} op_t;

    typedef struct packed {
        op_t op;
        logic [15:0] reg_list;
        logic [3:0] store_reg;
        logic [3:0] base_reg;
        logic [31:0] base;
        logic [31:0] pc;
        logic writeback;
        logic user_store;
        logic mode_trans;
        logic compact;
        logic next_uses_last;
    } cmd_t;

    typedef struct packed {
        logic [31:0] fetch_address;
        logic fetch_request_n;
        logic fetch_sequential;
    } fetch_req_t;

    typedef struct packed {
        logic [31:0] data_side_address;
        logic data_request_n;
        logic data_sequential;
        logic data_translate_n;
    } data_req_t;

    typedef struct packed {
        logic [3:0] index;
        logic [31:0] value;
    } reg_write_t;

    localparam fetch_req_t FETCH_RESET = '{32'h0000_0000, 1'b1, 1'b0};
    localparam data_req_t DATA_RESET = '{32'h0000_0000, 1'b1, 1'b0, 1'b1};

endpackage

// file: src/load_store_multiple_sequencer.sv
// Sequencer for single store, block load, block store and double load.
// Assumes memory answers reads and takes write data one cycle after the address.
// Operation
// - Single store completes in one execute cycle
// - Store issues nonsequential request, translate per variant
// - Block load pipelines address, data, base
// - Abort mutes every later register write
// - Abort restores original base at completion
// - Loading program counter discards fetched instructions
// - Program counter is always loaded last
// - Dependent follower of multi-word load stalls once, unless the load includes the program counter
// - One-word block load never stalls follower
// - Block load request sequence and late fetch
// - Program counter load adds idle then refill
// - Interlock adds idle data cycle n+1
// - Block store computes address and base first
// - Store write data trails its address
// - Block store request sequence per word count
// - Double load behaves as two-word block load
// - Compact pop with counter acts as load
module load_store_multiple_sequencer
    import lsm_pkg::*;
#(
    parameter int BUF_DEPTH = CMD_BUF_DEPTH
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Instructions from decode
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    output logic cmd_ready,
    // Register bank read port for store data
    output logic [3:0] store_reg_index,
    input wire logic [DATA_W-1:0] store_reg_value,
    // Instruction side
    output fetch_req_t fetch,
    // Data side
    output data_req_t data_req,
    output logic [DATA_W-1:0] write_data,
    input wire logic [DATA_W-1:0] read_data,
    input wire logic data_abort,
    // Register writeback
    output logic reg_write_valid,
    output reg_write_t reg_write,
    // Base update, refill and interlock
    output logic base_write_valid,
    output logic [ADDR_W-1:0] base_write_value,
    output logic pc_flush,
    output logic interlock_stall
);

    localparam int PTR_W = $clog2(BUF_DEPTH);

    // Refuse depths the pointer wrap cannot serve
    if (BUF_DEPTH < 2 || (1 << PTR_W) != BUF_DEPTH)
    begin : g_bad_depth
        $error("BUF_DEPTH must be a power of two, at least 2");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_TAIL, ST_REFILL} seq_state_t;

    function automatic logic [3:0] lowest_index(input logic [15:0] mask);
        lowest_index = 4'h0;
        for (int k = REG_COUNT - 1; k >= 0; k--)
        begin
            if (mask[k])
                lowest_index = 4'(k);
        end
    endfunction

    function automatic logic [4:0] word_count(input logic [15:0] mask);
        word_count = 5'h00;
        for (int k = 0; k < REG_COUNT; k++)
        begin
            word_count = word_count + 5'(mask[k]);
        end
    endfunction

    function automatic logic [15:0] drop_lowest(input logic [15:0] mask);
        drop_lowest = mask & (mask - 16'h0001);
    endfunction

    // Command buffer
    cmd_t q_mem [BUF_DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] q_count;
    logic [PTR_W:0] next_q_count;
    logic q_push;
    logic take;
    cmd_t head;

    // Sequencing state
    seq_state_t state;
    logic [15:0] pending;
    logic [31:0] step;
    logic [31:0] pc_ahead;
    logic [1:0] refill_cnt;
    logic is_load;
    logic blk;
    logic has_pc;
    logic multi;
    logic dep;
    logic wb;
    logic base_in_list;
    logic [31:0] orig_base;
    logic [31:0] new_base;
    logic aborted;

    // Address-cycle and answer-cycle tags
    logic ld_issue;
    logic wr_issue;
    logic first_issue;
    logic issue_last;
    logic [3:0] issue_idx;
    logic back_load;
    logic back_store;
    logic back_last;
    logic [3:0] back_idx;

    // Decoded head command
    logic [15:0] hlist;
    logic [15:0] hrest;
    logic [31:0] hstep;
    logic hload;
    logic abort_any;

    assign q_push = cmd_valid & cmd_ready;
    // Hold the next command until the last answer of a block has used its attributes
    assign take = (q_count != '0) && (state == ST_IDLE) && !(issue_last && blk);
    assign next_q_count = q_count + (PTR_W + 1)'(q_push) - (PTR_W + 1)'(take);
    assign head = q_mem[rd_ptr];
    assign hload = (head.op == OP_BLOCK_LOAD) || (head.op == OP_DOUBLE_LOAD);
    // Double load is a two-register list from its first destination
    assign hlist = (head.op == OP_DOUBLE_LOAD) ? (DOUBLE_PAIR << head.store_reg)
                                               : head.reg_list;
    assign hrest = drop_lowest(hlist);
    assign hstep = head.compact ? COMPACT_FETCH_STEP : WIDE_FETCH_STEP;
    assign abort_any = aborted | ((back_load | back_store) & data_abort);

    // Command buffer storage and pointers; decode stalls while it is full
    always_ff @(posedge clk_sys)
    begin
        if (q_push)
            q_mem[wr_ptr] <= cmd;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            q_count <= '0;
            cmd_ready <= 1'b0;
        end
        else
        begin
            wr_ptr <= wr_ptr + PTR_W'(q_push);
            rd_ptr <= rd_ptr + PTR_W'(take);
            q_count <= next_q_count;
            cmd_ready <= next_q_count != (PTR_W + 1)'(BUF_DEPTH);
        end
    end

    // Cycle sequencing of both memory interfaces
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            fetch <= FETCH_RESET;
            data_req <= DATA_RESET;
            store_reg_index <= 4'h0;
            pending <= 16'h0000;
            step <= WIDE_FETCH_STEP;
            pc_ahead <= 32'h0000_0000;
            refill_cnt <= 2'h0;
            ld_issue <= 1'b0;
            wr_issue <= 1'b0;
            first_issue <= 1'b0;
            issue_last <= 1'b0;
            issue_idx <= 4'h0;
            interlock_stall <= 1'b0;
            pc_flush <= 1'b0;
        end
        else
        begin
            ld_issue <= 1'b0;
            wr_issue <= 1'b0;
            first_issue <= 1'b0;
            issue_last <= 1'b0;
            interlock_stall <= 1'b0;
            pc_flush <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    {fetch.fetch_request_n, fetch.fetch_sequential} <= CYC_IDLE;
                    {data_req.data_request_n, data_req.data_sequential} <= CYC_IDLE;
                    if (take)
                    begin
                        // First cycle: first address out; prefetch address set, but only a single store requests it
                        step <= hstep;
                        pc_ahead <= head.pc + FETCH_AHEAD * hstep;
                        fetch.fetch_address <= head.pc + FETCH_AHEAD * hstep;
                        data_req.data_side_address <= head.base;
                        {data_req.data_request_n, data_req.data_sequential} <= CYC_NONSEQ;
                        data_req.data_translate_n <= (head.op == OP_STORE && head.user_store)
                                                     ? TRANS_USER : head.mode_trans;
                        first_issue <= 1'b1;
                        if (head.op == OP_STORE)
                        begin
                            // Single store: one execute cycle, prefetch continues
                            {fetch.fetch_request_n, fetch.fetch_sequential} <= CYC_SEQ;
                            store_reg_index <= head.store_reg;
                            wr_issue <= 1'b1;
                            issue_last <= 1'b1;
                        end
                        else
                        begin
                            {fetch.fetch_request_n, fetch.fetch_sequential} <= CYC_IDLE;
                            store_reg_index <= lowest_index(hlist);
                            issue_idx <= lowest_index(hlist);
                            pending <= hrest;
                            ld_issue <= hload;
                            wr_issue <= ~hload;
                            issue_last <= hrest == 16'h0000;
                            state <= (hrest == 16'h0000) ? ST_TAIL : ST_XFER;
                        end
                    end
                end
                ST_XFER:
                begin
                    // Later cycles: next sequential address, word of last cycle answered
                    data_req.data_side_address <= data_req.data_side_address + WORD_STEP;
                    {data_req.data_request_n, data_req.data_sequential} <= CYC_SEQ;
                    store_reg_index <= lowest_index(pending);
                    issue_idx <= lowest_index(pending);
                    pending <= drop_lowest(pending);
                    ld_issue <= is_load;
                    wr_issue <= ~is_load;
                    if (drop_lowest(pending) == 16'h0000)
                    begin
                        issue_last <= 1'b1;
                        if (!is_load || (!has_pc && !dep))
                        begin
                            fetch.fetch_address <= pc_ahead;
                            {fetch.fetch_request_n, fetch.fetch_sequential} <= CYC_SEQ;
                            state <= ST_IDLE;
                        end
                        else
                        begin
                            state <= ST_TAIL;
                        end
                    end
                end
                ST_TAIL:
                begin
                    // Idle data cycle while the last word returns
                    {data_req.data_request_n, data_req.data_sequential} <= CYC_IDLE;
                    interlock_stall <= multi & dep & ~has_pc;
                    if (has_pc)
                    begin
                        refill_cnt <= 2'h0;
                        state <= ST_REFILL;
                    end
                    else
                    begin
                        fetch.fetch_address <= pc_ahead;
                        {fetch.fetch_request_n, fetch.fetch_sequential} <= CYC_SEQ;
                        state <= ST_IDLE;
                    end
                end
                ST_REFILL:
                begin
                    // Pipeline refill from the loaded target unless the load aborted
                    refill_cnt <= refill_cnt + 2'h1;
                    if (refill_cnt == 2'h0 && !abort_any)
                    begin
                        fetch.fetch_address <= read_data;
                        {fetch.fetch_request_n, fetch.fetch_sequential} <= CYC_NONSEQ;
                        pc_flush <= 1'b1;
                    end
                    else if (refill_cnt == 2'h0 || refill_cnt == REFILL_LAST)
                    begin
                        {fetch.fetch_request_n, fetch.fetch_sequential} <= CYC_IDLE;
                        state <= ST_IDLE;
                    end
                    else
                    begin
                        fetch.fetch_address <= fetch.fetch_address + step;
                        {fetch.fetch_request_n, fetch.fetch_sequential} <= CYC_SEQ;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Per-instruction attributes caught when the command is taken
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            is_load <= 1'b0;
            blk <= 1'b0;
            has_pc <= 1'b0;
            multi <= 1'b0;
            dep <= 1'b0;
            wb <= 1'b0;
            base_in_list <= 1'b0;
            orig_base <= 32'h0000_0000;
            new_base <= 32'h0000_0000;
        end
        else if (take)
        begin
            is_load <= hload;
            blk <= head.op != OP_STORE;
            has_pc <= hload & hlist[PC_INDEX];
            multi <= word_count(hlist) > 5'h01;
            dep <= head.next_uses_last;
            wb <= head.writeback & (head.op != OP_STORE);
            base_in_list <= hlist[head.base_reg] & (head.op != OP_STORE);
            orig_base <= head.base;
            new_base <= head.base + {25'h0000000, word_count(hlist), 2'b00};
        end
    end

    // Answer-cycle tags, one cycle behind each address
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            back_load <= 1'b0;
            back_store <= 1'b0;
            back_last <= 1'b0;
            back_idx <= 4'h0;
        end
        else
        begin
            back_load <= ld_issue;
            back_store <= wr_issue;
            back_last <= issue_last & (ld_issue | wr_issue) & blk;
            back_idx <= issue_idx;
        end
    end

    // Abort memory: cleared by the next instruction, set by an aborted answer
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            aborted <= 1'b0;
        else if (take)
            aborted <= 1'b0;
        else if ((back_load | back_store) & data_abort)
            aborted <= 1'b1;
    end

    // Store data trails its address by one cycle
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            write_data <= '0;
        else if (wr_issue)
            write_data <= store_reg_value;
    end

    // Loaded words go to the register bank; counter and aborted words do not
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_write_valid <= 1'b0;
            reg_write <= '0;
        end
        else
        begin
            reg_write_valid <= back_load & ~abort_any & (back_idx != PC_INDEX);
            reg_write <= '{back_idx, read_data};
        end
    end

    // Base update: stores write early, loads at the end; abort restores
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            base_write_valid <= 1'b0;
            base_write_value <= '0;
        end
        else if (back_last && abort_any)
        begin
            base_write_valid <= wb | base_in_list;
            base_write_value <= orig_base;
        end
        else if ((back_last && is_load) || (first_issue && blk && !is_load))
        begin
            base_write_valid <= wb;
            base_write_value <= new_base;
        end
        else
        begin
            base_write_valid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence s_take_store;
        take && head.op == OP_STORE;
    endsequence

    sequence s_store_cycles;
        !data_req.data_request_n && !data_req.data_sequential && wr_issue
        ##1 write_data == $past(store_reg_value);
    endsequence

    property p_store_one;
        s_take_store |=> s_store_cycles;
    endproperty
    a_store_one: assert property (p_store_one) else $error("single store sequence wrong");

    property p_store_trans;
        take && head.op == OP_STORE && head.user_store |=> !data_req.data_translate_n;
    endproperty
    a_store_trans: assert property (p_store_trans) else $error("user store not marked");

    property p_seq_incr;
        !data_req.data_request_n && data_req.data_sequential
            |-> data_req.data_side_address == $past(data_req.data_side_address) + WORD_STEP;
    endproperty
    a_seq_incr: assert property (p_seq_incr) else $error("sequential address not +4");

    property p_abort_mute;
        back_load && abort_any |=> !reg_write_valid;
    endproperty
    a_abort_mute: assert property (p_abort_mute) else $error("write after abort");

    property p_restore;
        back_last && abort_any && wb |=> base_write_valid && base_write_value == $past(orig_base);
    endproperty
    a_restore: assert property (p_restore) else $error("base not restored");

    sequence s_refill;
        !fetch.fetch_request_n && !fetch.fetch_sequential
        ##1 fetch.fetch_sequential && fetch.fetch_address == $past(fetch.fetch_address) + step
        ##1 fetch.fetch_sequential && fetch.fetch_address == $past(fetch.fetch_address) + step;
    endsequence

    property p_refill;
        pc_flush |-> s_refill;
    endproperty
    a_refill: assert property (p_refill) else $error("refill fetches wrong");

    property p_flush_cause;
        pc_flush |-> has_pc && !aborted && $past(state) == ST_REFILL;
    endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("flush without counter load");

    property p_interlock;
        interlock_stall |-> multi && dep && data_req.data_request_n && fetch.fetch_sequential;
    endproperty
    a_interlock: assert property (p_interlock) else $error("bad interlock cycle");

    property p_single_no_stall;
        !multi |-> !interlock_stall;
    endproperty
    a_single_no_stall: assert property (p_single_no_stall) else $error("one-word stall");

    property p_cycle_kind;
        (data_req.data_request_n |-> !data_req.data_sequential)
            and (fetch.fetch_request_n |-> !fetch.fetch_sequential);
    endproperty
    a_cycle_kind: assert property (p_cycle_kind) else $error("illegal cycle type");

    property p_pc_last;
        back_load && back_idx == PC_INDEX |-> back_last;
    endproperty
    a_pc_last: assert property (p_pc_last) else $error("counter not loaded last");

endmodule

// file: tb/lsm_mem_model.sv
// Memory system model for the sequencer's data side.
// Assumes data requests are sampled on the rising edge of clk_sys.
module lsm_mem_model
    import lsm_pkg::*;
#(
    parameter logic [31:0] MASK = 32'hC3C3_0000
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Data side
    input wire data_req_t data_req,
    input wire logic [31:0] abort_addr,
    output logic [31:0] read_data,
    output logic data_abort
);
    timeunit 1ns;
    timeprecision 1ps;

    // Answer one cycle after each address; idle cycles toggle the bus
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_data <= 32'h0000_0000;
            data_abort <= 1'b0;
        end
        else if (!data_req.data_request_n)
        begin
            read_data <= data_req.data_side_address ^ MASK;
            data_abort <= (data_req.data_side_address == abort_addr);
        end
        else
        begin
            read_data <= ~read_data;
            data_abort <= 1'b0;
        end
    end
endmodule

// file: tb/tb.sv
// Self-checking bench for the load/store-multiple sequencer.
// Assumes the memory model answers one cycle after each address.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lsm_pkg::*;

    typedef struct packed {
        op_t op;
        logic [15:0] list;
        logic us, mt, cp, dep, stall, flush;
    } row_t;

    logic clk_sys, reset_n, cmd_valid, cmd_ready, reg_write_valid, base_write_valid;
    logic pc_flush, interlock_stall, data_abort, wr_pend;
    cmd_t cmd, cur;
    fetch_req_t fetch;
    data_req_t data_req;
    reg_write_t reg_write;
    logic [3:0] store_reg_index, wr_idx;
    logic [31:0] store_reg_value, write_data, read_data, base_write_value, abort_addr, last_base;
    logic [31:0] fexp;
    int bad_count = 0, n_checks = 0, nreq = 0, nwr = 0, nfl = 0, nst = 0, nbw = 0, cyc = 0;
    row_t rows [11] = '{
        '{OP_STORE, 16'h0004, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{OP_STORE, 16'h0004, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{OP_STORE, 16'h0004, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
        '{OP_BLOCK_LOAD, 16'h0002, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
        '{OP_BLOCK_LOAD, 16'h000E, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0},
        '{OP_BLOCK_LOAD, 16'h000E, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{OP_BLOCK_STORE, 16'h0070, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{OP_BLOCK_STORE, 16'h0100, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{OP_DOUBLE_LOAD, 16'h000C, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0},
        '{OP_BLOCK_LOAD, 16'h8003, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1},
        '{OP_BLOCK_LOAD, 16'h8001, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1}};

    // Combinational register bank read port
    assign store_reg_value = 32'hA500_0000 | {28'h0, store_reg_index};

    load_store_multiple_sequencer #(.BUF_DEPTH(CMD_BUF_DEPTH)) load_store_multiple_sequencer_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .store_reg_index(store_reg_index),
        .store_reg_value(store_reg_value), .fetch(fetch), .data_req(data_req),
        .write_data(write_data), .read_data(read_data), .data_abort(data_abort),
        .reg_write_valid(reg_write_valid), .reg_write(reg_write),
        .base_write_valid(base_write_valid), .base_write_value(base_write_value),
        .pc_flush(pc_flush), .interlock_stall(interlock_stall));

    lsm_mem_model lsm_mem_model_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .data_req(data_req), .abort_addr(abort_addr), .read_data(read_data),
        .data_abort(data_abort));

    function automatic logic [3:0] nth(input logic [15:0] l, input int k);
        int c;
        nth = 4'h0;
        c = 0;
        for (int i = 0; i < 16; i++)
            if (l[i])
            begin
                if (c == k)
                    nth = 4'(i);
                c++;
            end
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Offer one command, then let it run to completion
    task automatic run(input op_t op, input logic [15:0] l, input logic us, mt, cp, dep);
        logic wb;
        wb = (op == OP_BLOCK_LOAD || op == OP_BLOCK_STORE);
        cur = '{op, l, 4'h2, 4'hD, 32'h0000_1000, 32'h0000_8000, wb, us, mt, cp, dep};
        {nreq, nwr, nfl, nst, nbw} = '0;
        @(posedge clk_sys);
        cmd <= cur;
        cmd_valid <= 1'b1;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        repeat (18) @(posedge clk_sys);
    endtask

    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Cycle ceiling against hangs
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            bad_count++;
            conclude();
        end
    end

    // Per-cycle monitor of both memory interfaces and the writeback side
    always @(negedge clk_sys)
    begin
        if (wr_pend === 1'b1)
            chk(write_data, 32'hA500_0000 | {28'h0, wr_idx});
        wr_pend = 1'b0;
        if (data_req.data_request_n === 1'b0)
        begin
            chk(data_req.data_side_address, cur.base + 32'(4 * nreq));
            chk({30'h0, data_req.data_request_n, data_req.data_sequential},
                {30'h0, (nreq == 0) ? CYC_NONSEQ : CYC_SEQ});
            if (cur.op == OP_STORE)
                chk({31'h0, data_req.data_translate_n},
                    {31'h0, cur.user_store ? TRANS_USER : cur.mode_trans});
            if (cur.op == OP_STORE || cur.op == OP_BLOCK_STORE)
            begin
                chk({28'h0, store_reg_index}, {28'h0, nth(cur.reg_list, nreq)});
                wr_pend = 1'b1;
                wr_idx = store_reg_index;
            end
            nreq++;
        end
        if (reg_write_valid === 1'b1)
        begin
            chk({28'h0, reg_write.index}, {28'h0, nth(cur.reg_list, nwr)});
            chk(reg_write.value, (cur.base + 32'(4 * nwr)) ^ 32'hC3C3_0000);
            nwr++;
        end
        if (pc_flush === 1'b1)
        begin
            chk(fetch.fetch_address,
                (cur.base + 32'(4 * ($countones(cur.reg_list) - 1))) ^ 32'hC3C3_0000);
            chk({30'h0, fetch.fetch_request_n, fetch.fetch_sequential},
                {30'h0, CYC_NONSEQ});
            nfl++;
            fexp = fetch.fetch_address + (cur.compact ? 32'h0000_0002 : 32'h0000_0004);
        end
        // Prefetch at pc+3i, or refill fetches one step apart after a flush
        if (fetch.fetch_request_n === 1'b0 && fetch.fetch_sequential === 1'b1)
        begin
            chk(fetch.fetch_address, (nfl > 0) ? fexp
                : cur.pc + (cur.compact ? 32'h0000_0006 : 32'h0000_000C));
            fexp = fexp + (cur.compact ? 32'h0000_0002 : 32'h0000_0004);
        end
        if (interlock_stall === 1'b1)
            nst++;
        if (base_write_valid === 1'b1)
        begin
            nbw++;
            last_base = base_write_value;
        end
    end

    // Main sequence
    initial
    begin
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        abort_addr = 32'hFFFF_FFF0;
        repeat (12) @(posedge clk_sys);
        chk({31'h0, cmd_ready}, 32'h0);
        chk({31'h0, data_req.data_request_n}, 32'h1);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, cmd_ready}, 32'h1);
        $display("reset test done");
        for (int i = 0; i < 11; i++)
        begin
            run(rows[i].op, rows[i].list, rows[i].us, rows[i].mt, rows[i].cp, rows[i].dep);
            chk(32'(nreq), 32'($countones(rows[i].list)));
            chk(32'(nwr), (rows[i].op inside {OP_STORE, OP_BLOCK_STORE}) ? 32'h0
                : 32'($countones(rows[i].list & 16'h7FFF)));
            chk(32'(nst), {31'h0, rows[i].stall});
            chk(32'(nfl), {31'h0, rows[i].flush});
            chk(32'(nbw), {31'h0, cur.writeback});
            if (cur.writeback)
                chk(last_base, cur.base + 32'(4 * nreq));
            $display("row test %0d done", i);
        end
        // Abort on the second word of a load, a store and a counter load
        @(posedge clk_sys);
        abort_addr <= 32'h0000_1004;
        run(OP_BLOCK_LOAD, 16'h001E, 1'b0, 1'b1, 1'b0, 1'b0);
        chk(32'(nwr), 32'h1);
        chk(last_base, 32'h0000_1000);
        run(OP_BLOCK_STORE, 16'h001E, 1'b0, 1'b1, 1'b0, 1'b0);
        chk(32'(nreq), 32'h4);
        chk(last_base, 32'h0000_1000);
        run(OP_BLOCK_LOAD, 16'h8006, 1'b0, 1'b1, 1'b0, 1'b0);
        chk(32'(nfl), 32'h0);
        chk(32'(nwr), 32'h1);
        $display("abort tests done");
        conclude();
    end
endmodule
